/* rtl/gic_group_ctrl.sv */
// Group inhibit and reprogramming trigger control of a power manager
`timescale 1ns/1ns
module gic_group_ctrl #(
    parameter int NUM_INT = gic_pkg::NUM_INT,
    parameter int NUM_GRP = gic_pkg::NUM_GRP
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [NUM_INT-1:0] i_int_n,
    input wire logic i_auto_power_up,
    input wire logic i_supply_ok,
    input wire logic [NUM_GRP-1:0] i_cmd_start,
    input wire logic [NUM_GRP-1:0] i_cmd_stop,
    input wire logic i_cfg_we,
    input wire logic [1:0] i_cfg_idx,
    input wire logic i_cfg_trigger,
    input wire logic [NUM_GRP-1:0] i_cfg_groups,
    input wire logic [NUM_GRP-1:0] i_prog_done,
    input wire logic [NUM_GRP-1:0] i_pg_in,
    output logic [NUM_GRP-1:0] o_pg_oe,
    output logic [NUM_GRP-1:0] o_pg_out,
    output logic [NUM_GRP-1:0] o_prog_req,
    output logic o_prog_status_clr,
    output logic [NUM_GRP-1:0] o_grp_on,
    output logic [NUM_INT-1:0] o_int_level,
    output logic [NUM_INT-1:0] o_cfg_trigger
);
    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    logic [NUM_INT-1:0] sync1_r;
    logic [NUM_INT-1:0] sync2_r;
    logic [NUM_INT-1:0] prev_r;
    logic [NUM_INT-1:0] int_fall;
    logic [NUM_INT-1:0] int_rise;
    logic [NUM_INT-1:0] int_low;

    // Reset to released so a reset never fakes an edge
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r <= '1;
        end else begin
            sync1_r <= i_int_n;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end
    assign int_fall = prev_r & ~sync2_r;
    assign int_rise = ~prev_r & sync2_r;
    assign int_low = ~sync2_r;

    // ------------------------------------------------------------
    // Interrupt configuration, one function bit per input
    // ------------------------------------------------------------
    logic [NUM_INT-1:0] trig_r;
    logic [NUM_GRP-1:0] inh_map_r [NUM_INT];

    // A single function bit makes inhibit and trigger exclusive
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            trig_r <= '0;
            for (int k = 0; k < NUM_INT; k++) begin
                inh_map_r[k] <= '0;
            end
        end else if (i_cfg_we) begin
            trig_r[i_cfg_idx] <= i_cfg_trigger;
            inh_map_r[i_cfg_idx] <= i_cfg_groups;
        end
    end

    // ------------------------------------------------------------
    // Per-group inhibit mask and trigger events
    // ------------------------------------------------------------
    logic [NUM_GRP-1:0] inhibit;
    logic [NUM_GRP-1:0] trig_fall;
    logic [NUM_GRP-1:0] trig_rise;
    logic supply_prev_r;
    logic supply_up;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            supply_prev_r <= 1'b0;
        end else begin
            supply_prev_r <= i_supply_ok;
        end
    end
    assign supply_up = i_supply_ok & ~supply_prev_r;

    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : g_grp
            logic [NUM_INT-1:0] hit;
            logic [1:0] st_r;
            logic want_r;
            gic_pkg::gic_grp_state_e st;

            // Inhibit reaches the group from any assigned low input in inhibit mode
            for (genvar k = 0; k < NUM_INT; k++) begin : g_hit
                assign hit[k] = int_low[k] & ~trig_r[k] & inh_map_r[k][g];
            end
            assign inhibit[g] = |hit;
            // Trigger k drives only group k
            if (g < NUM_INT) begin : g_trig
                assign trig_fall[g] = int_fall[g] & trig_r[g];
                assign trig_rise[g] = int_rise[g] & trig_r[g];
            end else begin : g_notrig
                assign trig_fall[g] = 1'b0;
                assign trig_rise[g] = 1'b0;
            end
            assign st = gic_pkg::gic_grp_state_e'(st_r);

            // Group sequencer; "want" holds a pending power-up request
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    st_r <= 2'(gic_pkg::GIC_GRP_OFF);
                    want_r <= 1'b0;
                end else if (trig_rise[g] || i_cmd_stop[g]) begin
                    st_r <= 2'(gic_pkg::GIC_GRP_OFF);
                    want_r <= 1'b0;
                end else if (trig_fall[g]) begin
                    // Programming is not blocked by inhibit
                    st_r <= 2'(gic_pkg::GIC_GRP_PROG);
                    want_r <= i_auto_power_up;
                end else begin
                    case (st)
                        gic_pkg::GIC_GRP_OFF: begin
                            if (i_cmd_start[g] ||
                                (supply_up && i_auto_power_up)) begin
                                st_r <= 2'(gic_pkg::GIC_GRP_WAIT);
                            end
                        end
                        gic_pkg::GIC_GRP_PROG: begin
                            if (i_prog_done[g]) begin
                                st_r <= want_r ? 2'(gic_pkg::GIC_GRP_WAIT)
                                               : 2'(gic_pkg::GIC_GRP_OFF);
                            end
                        end
                        gic_pkg::GIC_GRP_WAIT: begin
                            // Held here while inhibited: deferred start
                            if (!inhibit[g]) begin
                                st_r <= 2'(gic_pkg::GIC_GRP_ON);
                            end
                        end
                        default: begin
                            st_r <= st_r;
                        end
                    endcase
                end
            end

            // Line driven low unless the group is on, not inhibited and not released by its trigger;
            // a three-cycle path (two synchroniser stages, then this register) keeps the inhibit latency well under 10 us
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    o_pg_oe[g] <= 1'b1;
                    o_grp_on[g] <= 1'b0;
                    o_prog_req[g] <= 1'b0;
                end else begin
                    o_pg_oe[g] <= inhibit[g]
                        || trig_rise[g]
                        || (st != gic_pkg::GIC_GRP_ON);
                    o_grp_on[g] <= (st == gic_pkg::GIC_GRP_ON) &&
                        !inhibit[g] && i_pg_in[g];
                    o_prog_req[g] <= (st == gic_pkg::GIC_GRP_PROG);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pg_out <= '0;
            o_prog_status_clr <= 1'b0;
            o_int_level <= '1;
            o_cfg_trigger <= '0;
        end else begin
            o_pg_out <= '0; // open-drain: only ever drives low
            o_prog_status_clr <= |trig_rise;
            o_int_level <= sync2_r;
            o_cfg_trigger <= trig_r;
        end
    end
endmodule // gic_group_ctrl

/* pkg/gic_pkg.sv */
// Package: constants and types for the group inhibit / interrupt control block
package gic_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_INT = 4;
    localparam int NUM_GRP = 4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INH_LATENCY_NS = 10000;
    // Longest time, rounds down
    localparam int INH_LATENCY_CYC = INH_LATENCY_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_GRP_EN = 4'h0;
    localparam logic [3:0] RST_ONEHOT_0 = 4'h1;
    // Per-group sequencer states
    typedef enum logic [1:0] {
        GIC_GRP_OFF,
        GIC_GRP_PROG,
        GIC_GRP_WAIT,
        GIC_GRP_ON
    } gic_grp_state_e;
endpackage

/* bench/gic_pol_model.sv */
// Partner model: converter groups on the power-good wires
`timescale 1ns/1ns
module gic_pol_model (
    input wire logic i_core_clk,
    input wire logic [3:0] i_pg_oe,
    input wire logic [3:0] i_prog_req,
    output logic [3:0] o_pg_wire,
    output logic [3:0] o_prog_done,
    output logic [3:0] o_rail_on
);
    logic [3:0] req1_r, req2_r, req3_r;
    logic [3:0] wire1_r, wire2_r, wire3_r, rail_r;
    // Pull-up holds the wire high unless the manager sinks it
    assign o_pg_wire = ~i_pg_oe;
    // Programming takes three cycles, so an instant answer is never seen
    always_ff @(posedge i_core_clk) begin
        req1_r <= i_prog_req;
        req2_r <= req1_r;
        req3_r <= req2_r;
    end
    assign o_prog_done = req3_r & i_prog_req;
    // Rails ramp down a fixed turn-off delay after the wire falls and come
    // back the same delay after release; no reset, reset flushes the chain
    always_ff @(posedge i_core_clk) begin
        wire1_r <= o_pg_wire;
        wire2_r <= wire1_r;
        wire3_r <= wire2_r;
        rail_r <= wire3_r;
    end
    assign o_rail_on = rail_r;
endmodule // gic_pol_model

/* bench/gic_group_ctrl_props.sv */
// Checker: port assertions for the group control block
`timescale 1ns/1ns
module gic_group_ctrl_props (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_int_n,
    input wire logic i_cfg_we,
    input wire logic [1:0] i_cfg_idx,
    input wire logic i_cfg_trigger,
    input wire logic [3:0] i_cfg_groups,
    input wire logic [3:0] o_pg_oe,
    input wire logic [3:0] o_pg_out,
    input wire logic [3:0] o_prog_req,
    input wire logic o_prog_status_clr,
    input wire logic [3:0] o_grp_on,
    input wire logic [3:0] o_int_level,
    input wire logic [3:0] o_cfg_trigger
);
    logic [3:0] m0_r;
    // Shadow of the inhibit mask of interrupt 0
    always_ff @(posedge i_core_clk) begin
        if (i_rst) m0_r <= 4'h0;
        else if (i_cfg_we && i_cfg_idx == 2'h0)
            m0_r <= i_cfg_groups & ~{4{i_cfg_trigger}};
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence low3; !o_int_level[0] [*3]; endsequence
    chk_od_low: assert property (o_pg_out == 4'h0)
        else $error("pg data high");
    chk_inh_hold: assert property (
        low3 ##0 m0_r != 0 |-> (o_pg_oe & m0_r) == m0_r) else $error("no hold");
    chk_inh_fast: assert property ($fell(i_int_n[0]) && m0_r != 0
        |-> ##[1:4] (o_pg_oe & m0_r) == m0_r) else $error("inhibit late");
    chk_sync_fall: assert property (
        $fell(i_int_n[0]) |-> ##[1:3] !o_int_level[0]) else $error("sync");
    chk_trig_prog: assert property (
        $fell(o_int_level[2]) && o_cfg_trigger[2] |-> ##[0:2] o_prog_req[2])
        else $error("no programming");
    chk_trig_rel: assert property (
        $rose(o_int_level[2]) && o_cfg_trigger[2]
        |-> ##[0:2] (o_prog_status_clr && o_pg_oe[2])) else $error("release");
    chk_clr_once: assert property (
        o_prog_status_clr |=> !o_prog_status_clr) else $error("clear long");
    chk_cfg_write: assert property (
        !$stable(o_cfg_trigger) |-> $past(i_cfg_we, 2)) else $error("mode moved");
endmodule // gic_group_ctrl_props
bind gic_group_ctrl gic_group_ctrl_props u_props (.i_core_clk, .i_rst,
    .i_int_n, .i_cfg_we, .i_cfg_idx, .i_cfg_trigger, .i_cfg_groups, .o_pg_oe,
    .o_pg_out, .o_prog_req, .o_prog_status_clr, .o_grp_on, .o_int_level,
    .o_cfg_trigger);

/* bench/gic_group_ctrl_bench.sv */
// Testbench: inhibit, trigger, host and auto power-up scenarios
`timescale 1ns/1ns
module gic_group_ctrl_bench;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_supply_ok = 1'b0;
    logic i_cfg_we = 1'b0, i_cfg_trigger = 1'b0, o_prog_status_clr;
    logic [1:0] i_cfg_idx = 2'h0;
    logic [3:0] i_int_n = 4'hf; // Sources released
    logic [3:0] i_cmd_start = 4'h0, i_cmd_stop = 4'h0, i_cfg_groups = 4'h0;
    logic [3:0] i_prog_done, i_pg_in, o_pg_oe, o_pg_out, o_prog_req;
    logic [3:0] o_grp_on, o_int_level, o_cfg_trigger, rail_on;
    logic i_auto_power_up = 1'b1;
    int n_errors = 0, total_checks = 0;
    always #5 i_core_clk = ~i_core_clk;
    gic_group_ctrl uut (.i_core_clk, .i_rst, .i_int_n,
        .i_auto_power_up, .i_supply_ok, .i_cmd_start, .i_cmd_stop,
        .i_cfg_we, .i_cfg_idx, .i_cfg_trigger, .i_cfg_groups, .i_prog_done,
        .i_pg_in, .o_pg_oe, .o_pg_out, .o_prog_req, .o_prog_status_clr,
        .o_grp_on, .o_int_level, .o_cfg_trigger);
    gic_pol_model u_pol (.i_core_clk, .i_pg_oe(o_pg_oe),
        .i_prog_req(o_prog_req), .o_pg_wire(i_pg_in),
        .o_prog_done(i_prog_done), .o_rail_on(rail_on));
    // Inputs move 1 ns after the edge to stay clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [3:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded poll, then settle so a passing glimpse is not enough
    task automatic expect_on(input string what, input logic [3:0] exp);
        for (int k = 0; k < 60 && o_grp_on !== exp; k++) step(1);
        step(5);
        check(what, exp, o_grp_on);
    endtask
    task automatic cfg(input logic [1:0] idx, input logic trig, logic [3:0] g);
        i_cfg_idx = idx;
        i_cfg_trigger = trig;
        i_cfg_groups = g;
        i_cfg_we = 1'b1;
        step(1);
        i_cfg_we = 1'b0;
    endtask
    task automatic t_defer();
        cfg(2'h0, 1'b0, 4'h1);
        i_int_n[0] = 1'b0;
        step(2);
        i_supply_ok = 1'b1;
        expect_on("auto on, group 0 held", 4'he);
        check("drive data", 4'h0, o_pg_out);
        i_int_n[0] = 1'b1;
        expect_on("group 0 after release", 4'hf);
        $display("test defer done");
    endtask
    task automatic t_inhibit();
        cfg(2'h1, 1'b0, 4'h6);
        i_int_n[1] = 1'b0;
        step(5);
        check("inhibit lines", 4'h6, o_pg_oe);
        check("synced levels", 4'hd, o_int_level);
        expect_on("inhibited groups", 4'h9);
        check("rails down", 4'h9, rail_on);
        i_int_n[1] = 1'b1;
        expect_on("restart", 4'hf);
        check("rails up", 4'hf, rail_on);
        $display("test inhibit done");
    endtask
    task automatic t_cmd();
        i_cmd_stop = 4'h8;
        step(1);
        i_cmd_stop = 4'h0;
        expect_on("host stop", 4'h7);
        i_cmd_start = 4'h8;
        step(1);
        i_cmd_start = 4'h0;
        expect_on("host start", 4'hf);
        $display("test host done");
    endtask
    task automatic t_trig();
        cfg(2'h2, 1'b1, 4'hf);
        step(1);
        check("mode bits", 4'h4, o_cfg_trigger);
        i_int_n[2] = 1'b0;
        step(4);
        check("programming", 4'h4, o_prog_req);
        expect_on("trigger power-up", 4'hf);
        i_int_n[2] = 1'b1;
        step(3);
        check("status clear", 4'h1, {3'h0, o_prog_status_clr});
        step(2);
        check("release drop", 4'h4, o_pg_oe);
        check("clear pulse", 4'h0, {3'h0, o_prog_status_clr});
        // Auto power-up off: programming ends with the group still off
        i_auto_power_up = 1'b0;
        i_int_n[2] = 1'b0;
        step(4);
        check("programming, no auto", 4'h4, o_prog_req);
        step(8);
        check("no auto power-up", 4'hb, o_grp_on);
        check("programming ended", 4'h0, o_prog_req);
        i_int_n[2] = 1'b1;
        i_auto_power_up = 1'b1;
        step(5);
        check("second release", 4'h4, o_pg_oe);
        $display("test trigger done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        step(10);
        i_rst = 1'b0;
        step(2);
        t_defer();
        t_inhibit();
        t_cmd();
        t_trig();
        summarize();
    end
    // Watchdog: tests need well under a thousand cycles
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
endmodule // gic_group_ctrl_bench
